//--- core/cantt_dev.sv
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module cantt_dev #(
  parameter int TICK_CYCLES = cantt_pkg::TICK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  cantt_link_if.dev link,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq
);
  localparam int TW = cantt_pkg::TW;
  // refused at elaboration: the prescaler cannot count below one cycle
  if (TICK_CYCLES < 1) begin
    $error("TICK_CYCLES must be at least one");
  end
  typedef enum logic [1:0] {R_IDLE, R_GRANT, R_WAIT_DT, R_ACK} cantt_rst_t;
  typedef enum logic [2:0] {O_IDLE, O_RTS, O_WAIT_CTS, O_HOLD, O_SEND, O_WAIT_ACK} cantt_ost_t;
  typedef enum logic [1:0] {B_IDLE, B_ANN, B_GAP, B_DT} cantt_bst_t;
  cantt_rst_t r_state_q;
  cantt_ost_t o_state_q;
  cantt_bst_t b_state_q;
  logic [31:0] pre_q;
  logic tick;
  logic [1:0] ctrl_q;
  logic [7:0] st_q, mask_q, ev, qsize_q;
  logic [TW-1:0] t_bcast_q, t_dir_q, t1_q, t2_q, t3_q, t4_q, ivl_q;
  logic [31:0] offset_q, arb_q;
  logic [15:0] fcnt_q;
  logic qs_fixed_q, cyc_d1_q, ivl_rst_q;
  logic [7:0] rx_total_q, rx_cnt_q, o_total_q, o_cnt_q, b_total_q, b_cnt_q;
  logic hold_sent_q;
  logic busy, cyc_en, ivl_wr, cmd_wr, cyc_start;
  logic rx_rts, rx_cts, rx_hold, rx_dt, rx_ack;
  logic r_req, o_req, b_req, r_gnt, o_gnt, b_gnt;
  cantt_pkg::cantt_msg_t r_kind, o_kind;
  logic tr_load, tr_stop, tr_exp, to_load, to_stop, to_exp, tb_load, tb_exp, tc_load, tc_exp;
  logic [TW-1:0] tr_lim, to_lim, tc_lim, off_eff, off_auto;
  logic tc_run;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) pre_q <= '0;
    else if (pre_q >= 32'(TICK_CYCLES - 1)) pre_q <= '0;
    else pre_q <= pre_q + 32'h1;
  end
  assign tick = (pre_q == 32'(TICK_CYCLES - 1));

  assign busy = ctrl_q[cantt_pkg::CTRL_BUSY];
  assign cyc_en = ctrl_q[cantt_pkg::CTRL_CYC_EN];
  assign ivl_wr = i_wr && (i_addr == cantt_pkg::A_INTERVAL);
  assign cmd_wr = i_wr && (i_addr == cantt_pkg::A_CMD);
  assign rx_rts = link.p2d_valid && (link.p2d_kind == cantt_pkg::MSG_RTS);
  assign rx_cts = link.p2d_valid && (link.p2d_kind == cantt_pkg::MSG_CTS);
  assign rx_hold = link.p2d_valid && (link.p2d_kind == cantt_pkg::MSG_HOLD);
  assign rx_dt = link.p2d_valid && (link.p2d_kind == cantt_pkg::MSG_DT);
  assign rx_ack = link.p2d_valid && (link.p2d_kind == cantt_pkg::MSG_ACK);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= '0;
      mask_q <= '0;
      t_bcast_q <= TW'(cantt_pkg::BCAST_RESP_MS);
      t_dir_q <= TW'(cantt_pkg::DIR_RESP_MS);
      t1_q <= TW'(cantt_pkg::T1_MS);
      t2_q <= TW'(cantt_pkg::T2_MS);
      t3_q <= TW'(cantt_pkg::T3_MS);
      t4_q <= TW'(cantt_pkg::T4_MS);
      offset_q <= cantt_pkg::OFFSET_RST;
      ivl_q <= TW'(cantt_pkg::IVL_DB_MS);
      arb_q <= '0;
    end else if (i_wr) begin
      case (i_addr)
        cantt_pkg::A_CTRL: ctrl_q <= i_wdata[1:0];
        cantt_pkg::A_MASK: mask_q <= i_wdata[7:0];
        cantt_pkg::A_T_BCAST: t_bcast_q <= i_wdata[TW-1:0];
        cantt_pkg::A_T_DIR: t_dir_q <= i_wdata[TW-1:0];
        cantt_pkg::A_T1: t1_q <= i_wdata[TW-1:0];
        cantt_pkg::A_T2: t2_q <= i_wdata[TW-1:0];
        cantt_pkg::A_T3: t3_q <= i_wdata[TW-1:0];
        cantt_pkg::A_T4: t4_q <= i_wdata[TW-1:0];
        cantt_pkg::A_OFFSET: offset_q <= i_wdata;
        cantt_pkg::A_INTERVAL: ivl_q <= i_wdata[TW-1:0];
        cantt_pkg::A_ARB_ID: arb_q <= i_wdata;
        default: ;
      endcase
    end
  end

  // set wins over the write-one clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) st_q <= '0;
    else if (i_wr && (i_addr == cantt_pkg::A_STATUS)) st_q <= (st_q & ~i_wdata[7:0]) | ev;
    else st_q <= st_q | ev;
  end
  assign o_irq = |(st_q & mask_q);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) o_rdata <= '0;
    else if (i_rd) begin
      case (i_addr)
        cantt_pkg::A_CTRL: o_rdata <= {30'h0, ctrl_q};
        cantt_pkg::A_STATUS: o_rdata <= {24'h0, st_q};
        cantt_pkg::A_MASK: o_rdata <= {24'h0, mask_q};
        cantt_pkg::A_T_BCAST: o_rdata <= 32'(t_bcast_q);
        cantt_pkg::A_T_DIR: o_rdata <= 32'(t_dir_q);
        cantt_pkg::A_T1: o_rdata <= 32'(t1_q);
        cantt_pkg::A_T2: o_rdata <= 32'(t2_q);
        cantt_pkg::A_T3: o_rdata <= 32'(t3_q);
        cantt_pkg::A_T4: o_rdata <= 32'(t4_q);
        cantt_pkg::A_OFFSET: o_rdata <= offset_q;
        cantt_pkg::A_INTERVAL: o_rdata <= 32'(ivl_q);
        cantt_pkg::A_ARB_ID: o_rdata <= arb_q;
        cantt_pkg::A_QSIZE: o_rdata <= {24'h0, qsize_q};
        cantt_pkg::A_STATE: o_rdata <= {24'h0, b_state_q, o_state_q, r_state_q, tc_run};
        cantt_pkg::A_FCNT: o_rdata <= {16'h0, fcnt_q};
        default: o_rdata <= '0;
      endcase
    end else o_rdata <= '0;
  end

  // fixed priority: responder answers never wait behind our own streams
  assign r_gnt = r_req;
  assign o_gnt = o_req && !r_req;
  assign b_gnt = b_req && !r_req && !o_req;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      link.d2p_valid <= 1'b0;
      link.d2p_kind <= cantt_pkg::MSG_RTS;
      link.d2p_data <= '0;
    end else begin
      link.d2p_valid <= r_req || o_req || b_req;
      if (r_gnt) begin
        link.d2p_kind <= r_kind;
        link.d2p_data <= rx_total_q;
      end else if (o_gnt) begin
        link.d2p_kind <= o_kind;
        link.d2p_data <= (o_state_q == O_RTS) ? o_total_q : o_cnt_q + 8'h1;
      end else if (b_gnt) begin
        link.d2p_kind <= (b_state_q == B_ANN) ? cantt_pkg::MSG_BAM : cantt_pkg::MSG_DT;
        link.d2p_data <= (b_state_q == B_ANN) ? b_total_q : b_cnt_q + 8'h1;
      end
    end
  end

  // responder
  assign r_req = ((r_state_q == R_GRANT) && (!busy || !hold_sent_q)) || (r_state_q == R_ACK);
  assign r_kind = (r_state_q == R_ACK) ? cantt_pkg::MSG_ACK :
                  (busy ? cantt_pkg::MSG_HOLD : cantt_pkg::MSG_CTS);
  // a hold is renewed each rx gap limit so the far end's hold timer never runs out
  assign tr_load = (r_gnt && (r_state_q == R_GRANT)) ||
                   (rx_dt && (r_state_q == R_WAIT_DT) && (rx_cnt_q + 8'h1 != rx_total_q));
  assign tr_lim = (r_state_q == R_WAIT_DT) ? t1_q : (busy ? t1_q : t2_q);
  assign tr_stop = (r_state_q == R_ACK) || (r_state_q == R_IDLE);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      r_state_q <= R_IDLE;
      rx_total_q <= '0;
      rx_cnt_q <= '0;
      hold_sent_q <= 1'b0;
    end else begin
      case (r_state_q)
        R_IDLE: if (rx_rts) begin
          rx_total_q <= link.p2d_data;
          rx_cnt_q <= '0;
          hold_sent_q <= 1'b0;
          r_state_q <= R_GRANT;
        end
        R_GRANT: begin
          if (r_gnt && busy) hold_sent_q <= 1'b1;
          else if (tr_exp) hold_sent_q <= 1'b0;
          if (r_gnt && !busy) r_state_q <= R_WAIT_DT;
        end
        R_WAIT_DT: begin
          if (rx_dt) begin
            rx_cnt_q <= rx_cnt_q + 8'h1;
            if (rx_cnt_q + 8'h1 == rx_total_q) r_state_q <= R_ACK;
          end else if (tr_exp) r_state_q <= R_IDLE;
        end
        R_ACK: if (r_gnt) r_state_q <= R_IDLE;
        default: r_state_q <= R_IDLE;
      endcase
    end
  end

  // originator
  assign o_req = (o_state_q == O_RTS) || (o_state_q == O_SEND);
  assign o_kind = (o_state_q == O_RTS) ? cantt_pkg::MSG_RTS : cantt_pkg::MSG_DT;
  assign to_load = (o_gnt && (o_state_q == O_RTS)) ||
                   (o_gnt && (o_cnt_q + 8'h1 == o_total_q)) ||
                   (rx_hold && ((o_state_q == O_WAIT_CTS) || (o_state_q == O_HOLD)));
  assign to_lim = rx_hold ? t4_q : t3_q;
  assign to_stop = (o_state_q == O_IDLE) || (o_state_q == O_SEND);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_state_q <= O_IDLE;
      o_total_q <= '0;
      o_cnt_q <= '0;
    end else begin
      case (o_state_q)
        O_IDLE: if (cmd_wr && i_wdata[cantt_pkg::CMD_RTS]) begin
          o_total_q <= i_wdata[cantt_pkg::CMD_CNT_LSB +: 8];
          o_state_q <= O_RTS;
        end
        O_RTS: if (o_gnt) o_state_q <= O_WAIT_CTS;
        O_WAIT_CTS, O_HOLD: begin
          o_cnt_q <= '0;
          if (rx_cts) o_state_q <= O_SEND;
          else if (rx_hold) o_state_q <= O_HOLD;
          else if (to_exp) o_state_q <= O_IDLE;
        end
        O_SEND: if (o_gnt) begin
          o_cnt_q <= o_cnt_q + 8'h1;
          if (o_cnt_q + 8'h1 == o_total_q) o_state_q <= O_WAIT_ACK;
        end
        O_WAIT_ACK: begin
          o_cnt_q <= '0;
          if (rx_ack) o_state_q <= O_IDLE;
          else if (rx_cts) o_state_q <= O_SEND;
          else if (rx_hold) o_state_q <= O_HOLD;
          else if (to_exp) o_state_q <= O_IDLE;
        end
        default: o_state_q <= O_IDLE;
      endcase
    end
  end

  // broadcast
  assign b_req = (b_state_q == B_ANN) || (b_state_q == B_DT);
  assign tb_load = b_gnt && !((b_state_q == B_DT) && (b_cnt_q + 8'h1 == b_total_q));
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      b_state_q <= B_IDLE;
      b_total_q <= '0;
      b_cnt_q <= '0;
    end else begin
      case (b_state_q)
        B_IDLE: if (cmd_wr && i_wdata[cantt_pkg::CMD_BAM]) begin
          b_total_q <= i_wdata[cantt_pkg::CMD_CNT_LSB +: 8];
          b_cnt_q <= '0;
          b_state_q <= B_ANN;
        end
        B_ANN: if (b_gnt) b_state_q <= B_GAP;
        B_GAP: if (tb_exp) b_state_q <= B_DT;
        B_DT: if (b_gnt) begin
          b_cnt_q <= b_cnt_q + 8'h1;
          b_state_q <= (b_cnt_q + 8'h1 == b_total_q) ? B_IDLE : B_GAP;
        end
        default: b_state_q <= B_IDLE;
      endcase
    end
  end

  // cyclic frame
  assign off_auto = (TW'(arb_q[7:0]) < ivl_q) ? TW'(arb_q[7:0]) : '0;
  assign off_eff = offset_q[31] ? off_auto : offset_q[TW-1:0];
  assign cyc_start = cyc_en && (!cyc_d1_q || ivl_rst_q);
  assign tc_load = cyc_start || (tc_exp && cyc_en);
  assign tc_lim = cyc_start ? off_eff : ivl_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cyc_d1_q <= 1'b0;
      ivl_rst_q <= 1'b0;
      link.frame_tx <= 1'b0;
      fcnt_q <= '0;
    end else begin
      cyc_d1_q <= cyc_en;
      ivl_rst_q <= ivl_wr && cyc_en;
      link.frame_tx <= tc_exp && cyc_en && !ivl_rst_q;
      if (tc_exp && cyc_en && !ivl_rst_q) fcnt_q <= fcnt_q + 16'h1;
    end
  end
  // a rate change later can leave the queue too small; software must size it up front
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      qs_fixed_q <= 1'b0;
      qsize_q <= cantt_pkg::QS_SHALLOW;
    end else if (cyc_start && !qs_fixed_q) begin
      qs_fixed_q <= 1'b1;
      qsize_q <= (ivl_q < TW'(cantt_pkg::QS_FAST_MS)) ? cantt_pkg::QS_DEEP : cantt_pkg::QS_SHALLOW;
    end
  end

  assign ev[cantt_pkg::ST_T1] = tr_exp && (r_state_q == R_WAIT_DT) && !rx_dt && (rx_cnt_q != 8'h0);
  assign ev[cantt_pkg::ST_T2] = tr_exp && (r_state_q == R_WAIT_DT) && !rx_dt && (rx_cnt_q == 8'h0);
  assign ev[cantt_pkg::ST_T3] = to_exp && (o_state_q != O_HOLD) && !rx_cts && !rx_hold && !rx_ack;
  assign ev[cantt_pkg::ST_T4] = to_exp && (o_state_q == O_HOLD) && !rx_cts && !rx_hold;
  assign ev[cantt_pkg::ST_TX_DONE] = rx_ack && (o_state_q == O_WAIT_ACK);
  assign ev[cantt_pkg::ST_RX_DONE] = r_gnt && (r_state_q == R_ACK);
  assign ev[cantt_pkg::ST_BAM_DONE] = b_gnt && (b_state_q == B_DT) && (b_cnt_q + 8'h1 == b_total_q);
  assign ev[cantt_pkg::ST_FRAME] = tc_exp && cyc_en && !ivl_rst_q;

  cantt_timer #(.W(TW)) u_tr (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_tick(tick),
    .i_load(tr_load), .i_stop(tr_stop), .i_limit(tr_lim), .o_expired(tr_exp), .o_running());
  cantt_timer #(.W(TW)) u_to (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_tick(tick),
    .i_load(to_load), .i_stop(to_stop), .i_limit(to_lim), .o_expired(to_exp), .o_running());
  cantt_timer #(.W(TW)) u_tb (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_tick(tick),
    .i_load(tb_load), .i_stop(b_state_q == B_IDLE), .i_limit(t_bcast_q), .o_expired(tb_exp),
    .o_running());
  cantt_timer #(.W(TW)) u_tc (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_tick(tick),
    .i_load(tc_load), .i_stop(!cyc_en), .i_limit(tc_lim), .o_expired(tc_exp), .o_running(tc_run));
endmodule
`default_nettype wire

//--- core/cantt_pkg.sv
package cantt_pkg;
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = (TICK_US * CLK_MHZ);
  localparam int TW = 18;
  localparam int BCAST_RESP_MS = 50;
  localparam int DIR_RESP_MS = 50;
  localparam int T1_MS = 750;
  localparam int T2_MS = 1250;
  localparam int T3_MS = 1250;
  localparam int T4_MS = 1050;
  localparam int IVL_DB_MS = 100;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_MASK = 8'h0c;
  localparam logic [7:0] A_T_BCAST = 8'h10;
  localparam logic [7:0] A_T_DIR = 8'h14;
  localparam logic [7:0] A_T1 = 8'h18;
  localparam logic [7:0] A_T2 = 8'h1c;
  localparam logic [7:0] A_T3 = 8'h20;
  localparam logic [7:0] A_T4 = 8'h24;
  localparam logic [7:0] A_OFFSET = 8'h28;
  localparam logic [7:0] A_INTERVAL = 8'h2c;
  localparam logic [7:0] A_ARB_ID = 8'h30;
  localparam logic [7:0] A_QSIZE = 8'h34;
  localparam logic [7:0] A_STATE = 8'h38;
  localparam logic [7:0] A_FCNT = 8'h3c;
  localparam int CTRL_CYC_EN = 0;
  localparam int CTRL_BUSY = 1;
  localparam int CMD_RTS = 0;
  localparam int CMD_BAM = 1;
  localparam int CMD_CNT_LSB = 8;
  localparam int ST_T1 = 0;
  localparam int ST_T2 = 1;
  localparam int ST_T3 = 2;
  localparam int ST_T4 = 3;
  localparam int ST_TX_DONE = 4;
  localparam int ST_RX_DONE = 5;
  localparam int ST_BAM_DONE = 6;
  localparam int ST_FRAME = 7;
  localparam logic [31:0] OFFSET_RST = 32'hffffffff;
  localparam int QS_FAST_MS = 20;
  localparam logic [7:0] QS_DEEP = 8'h40;
  localparam logic [7:0] QS_SHALLOW = 8'h10;
  typedef enum logic [2:0] {MSG_RTS, MSG_CTS, MSG_HOLD, MSG_DT, MSG_ACK, MSG_BAM} cantt_msg_t;
endpackage

//--- core/cantt_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cantt_link_if;
  logic d2p_valid;
  cantt_pkg::cantt_msg_t d2p_kind;
  logic [7:0] d2p_data;
  logic p2d_valid;
  cantt_pkg::cantt_msg_t p2d_kind;
  logic [7:0] p2d_data;
  logic frame_tx;
  modport dev (output d2p_valid, output d2p_kind, output d2p_data, output frame_tx,
               input p2d_valid, input p2d_kind, input p2d_data);
  modport partner (input d2p_valid, input d2p_kind, input d2p_data, input frame_tx,
                   output p2d_valid, output p2d_kind, output p2d_data);
endinterface
`default_nettype wire

//--- core/cantt_timer.sv
`timescale 1ns/1ns
`default_nettype none
module cantt_timer #(
  parameter int W = 18
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic i_stop,
  input wire logic [W-1:0] i_limit,
  output logic o_expired,
  output logic o_running
);
  logic [W-1:0] cnt_q;
  // expires on the limit-th tick after load; tick phase makes it up to one tick early
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      o_running <= 1'b0;
      o_expired <= 1'b0;
    end else begin
      o_expired <= 1'b0;
      if (i_load) begin
        cnt_q <= i_limit;
        o_running <= 1'b1;
      end else if (i_stop) begin
        o_running <= 1'b0;
      end else if (o_running && i_tick) begin
        if (cnt_q <= W'(1)) begin
          o_running <= 1'b0;
          o_expired <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- core/cantt_partner.sv
`timescale 1ns/1ns
`default_nettype none
module cantt_partner #(
  parameter int GAP_CYCLES = 1000000,
  parameter int HOLD_RENEW_CYCLES = 1000000
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  cantt_link_if.partner link,
  input wire logic i_busy,
  input wire logic i_send_rts,
  input wire logic [7:0] i_count,
  output logic o_rx_done,
  output logic o_tx_done,
  output logic [15:0] o_frames
);
  if (GAP_CYCLES < 1 || HOLD_RENEW_CYCLES < 1) begin
    $error("partner spacing must be positive");
  end
  typedef enum logic [1:0] {P_IDLE, P_GRANT, P_WAIT_DT, P_ACK} cantt_prs_t;
  typedef enum logic [1:0] {Q_IDLE, Q_RTS, Q_WAIT, Q_SEND} cantt_pos_t;
  cantt_prs_t r_q;
  cantt_pos_t o_q;
  logic [7:0] r_tot_q, r_cnt_q, o_tot_q, o_cnt_q;
  logic [31:0] hold_cnt_q, gap_cnt_q;
  logic rx_rts, rx_cts, rx_dt, rx_ack, r_req, o_req, gap_ok, hold_due;
  assign rx_rts = link.d2p_valid && (link.d2p_kind == cantt_pkg::MSG_RTS);
  assign rx_cts = link.d2p_valid && (link.d2p_kind == cantt_pkg::MSG_CTS);
  assign rx_dt = link.d2p_valid && (link.d2p_kind == cantt_pkg::MSG_DT);
  assign rx_ack = link.d2p_valid && (link.d2p_kind == cantt_pkg::MSG_ACK);
  assign hold_due = (hold_cnt_q == 32'h0);
  assign gap_ok = (gap_cnt_q == 32'h0);
  assign r_req = ((r_q == P_GRANT) && (!i_busy || hold_due)) || (r_q == P_ACK);
  assign o_req = (o_q == Q_RTS) || ((o_q == Q_SEND) && gap_ok);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      link.p2d_valid <= 1'b0;
      link.p2d_kind <= cantt_pkg::MSG_RTS;
      link.p2d_data <= '0;
    end else begin
      link.p2d_valid <= r_req || o_req;
      if (r_req) begin
        link.p2d_kind <= (r_q == P_ACK) ? cantt_pkg::MSG_ACK :
                         (i_busy ? cantt_pkg::MSG_HOLD : cantt_pkg::MSG_CTS);
        link.p2d_data <= r_tot_q;
      end else if (o_req) begin
        link.p2d_kind <= (o_q == Q_RTS) ? cantt_pkg::MSG_RTS : cantt_pkg::MSG_DT;
        link.p2d_data <= (o_q == Q_RTS) ? o_tot_q : o_cnt_q + 8'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      r_q <= P_IDLE;
      r_tot_q <= '0;
      r_cnt_q <= '0;
      hold_cnt_q <= '0;
      o_rx_done <= 1'b0;
    end else begin
      o_rx_done <= 1'b0;
      case (r_q)
        P_IDLE: if (rx_rts) begin
          r_tot_q <= link.d2p_data;
          r_cnt_q <= '0;
          hold_cnt_q <= '0;
          r_q <= P_GRANT;
        end
        P_GRANT: begin
          if (r_req && i_busy) hold_cnt_q <= 32'(HOLD_RENEW_CYCLES - 1);
          else if (!hold_due) hold_cnt_q <= hold_cnt_q - 32'h1;
          if (r_req && !i_busy) r_q <= P_WAIT_DT;
        end
        P_WAIT_DT: if (rx_dt) begin
          r_cnt_q <= r_cnt_q + 8'h1;
          if (r_cnt_q + 8'h1 == r_tot_q) r_q <= P_ACK;
        end
        P_ACK: if (!o_req || r_req) begin
          o_rx_done <= 1'b1;
          r_q <= P_IDLE;
        end
        default: r_q <= P_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_q <= Q_IDLE;
      o_tot_q <= '0;
      o_cnt_q <= '0;
      gap_cnt_q <= '0;
      o_tx_done <= 1'b0;
    end else begin
      o_tx_done <= 1'b0;
      if (!gap_ok) gap_cnt_q <= gap_cnt_q - 32'h1;
      case (o_q)
        Q_IDLE: if (i_send_rts) begin
          o_tot_q <= i_count;
          o_q <= Q_RTS;
        end
        Q_RTS: if (!r_req) o_q <= Q_WAIT;
        Q_WAIT: begin
          if (rx_cts) begin
            o_cnt_q <= '0;
            gap_cnt_q <= '0;
            o_q <= Q_SEND;
          end else if (rx_ack) begin
            o_tx_done <= 1'b1;
            o_q <= Q_IDLE;
          end
        end
        Q_SEND: if (o_req && !r_req) begin
          o_cnt_q <= o_cnt_q + 8'h1;
          gap_cnt_q <= 32'(GAP_CYCLES - 1);
          if (o_cnt_q + 8'h1 == o_tot_q) o_q <= Q_WAIT;
        end
        default: o_q <= Q_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) o_frames <= '0;
    else if (link.frame_tx) o_frames <= o_frames + 16'h1;
  end
endmodule
`default_nettype wire

//--- verif/cantt_link_checker.sv
`timescale 1ns/1ns
`default_nettype none
module cantt_link_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic d2p_valid,
  input wire cantt_pkg::cantt_msg_t d2p_kind,
  input wire logic [7:0] d2p_data,
  input wire logic p2d_valid,
  input wire cantt_pkg::cantt_msg_t p2d_kind,
  input wire logic [7:0] p2d_data,
  input wire logic frame_tx
);
  // bench sets a 10-cycle tick, so 50 ticks plus slack
  localparam int BCAST_MAX = 520;
  logic [7:0] cnt_q;
  wire d_rts = d2p_valid && d2p_kind == cantt_pkg::MSG_RTS;
  wire d_cts = d2p_valid && d2p_kind == cantt_pkg::MSG_CTS;
  wire d_hold = d2p_valid && d2p_kind == cantt_pkg::MSG_HOLD;
  wire d_ack = d2p_valid && d2p_kind == cantt_pkg::MSG_ACK;
  wire d_bam = d2p_valid && d2p_kind == cantt_pkg::MSG_BAM;
  wire d_dt = d2p_valid && d2p_kind == cantt_pkg::MSG_DT;
  wire p_rts = p2d_valid && p2d_kind == cantt_pkg::MSG_RTS;
  wire p_cts = p2d_valid && p2d_kind == cantt_pkg::MSG_CTS;
  wire p_hold = p2d_valid && p2d_kind == cantt_pkg::MSG_HOLD;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  sequence s_dt_run;
    d_dt ##1 d_dt;
  endsequence
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 8'h00;
    end else if (p_rts) begin
      cnt_q <= p2d_data;
    end
  end
  a_rts_answered: assert property (p_rts |-> ##2 (d_cts || d_hold))
    else $error("request not answered");
  a_grant_echo: assert property ((d_cts || d_hold || d_ack) |-> d2p_data == cnt_q)
    else $error("echoed count wrong");
  a_cts_starts_dt: assert property (p_cts |-> ##2 (d_dt && d2p_data == 8'h01))
    else $error("grant not followed by data");
  a_dt_counts_up: assert property (s_dt_run |-> d2p_data == $past(d2p_data) + 8'h01)
    else $error("data sequence skipped");
  a_rts_waits_cts: assert property (d_rts |=> !d_dt until p_cts)
    else $error("data before grant");
  a_far_prompt: assert property (d_rts |-> ##[1:1000] (p_cts || p_hold))
    else $error("far end silent");
  a_bam_paced: assert property (d_bam |-> ##[1:BCAST_MAX] d_dt)
    else $error("broadcast data late");
  a_frame_single: assert property (frame_tx |=> !frame_tx [*8])
    else $error("frames too close");
endmodule
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int TC = 10;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_busy = 1'b0;
  logic i_send_rts = 1'b0;
  logic [7:0] i_count = 8'h02;
  logic [31:0] o_rdata;
  logic o_irq;
  logic [15:0] o_frames;
  logic [31:0] rv;
  logic [31:0] tv [6] = '{32'h32, 32'h32, 32'h2ee, 32'h4e2, 32'h4e2, 32'h41a};
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int fr_n = 0;
  int fr_at = 0;
  int holds = 0;
  int t0 = 0;
  cantt_link_if link ();
  cantt_dev #(.TICK_CYCLES(TC)) i_cantt_dev (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(link),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
  cantt_partner #(.GAP_CYCLES(5), .HOLD_RENEW_CYCLES(20)) i_cantt_partner (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .link(link), .i_busy(i_busy), .i_send_rts(i_send_rts), .i_count(i_count),
    .o_rx_done(), .o_tx_done(), .o_frames(o_frames));
  cantt_link_checker i_cantt_link_checker (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .d2p_valid(link.d2p_valid), .d2p_kind(link.d2p_kind), .d2p_data(link.d2p_data),
    .p2d_valid(link.p2d_valid), .p2d_kind(link.p2d_kind), .p2d_data(link.p2d_data),
    .frame_tx(link.frame_tx));
  always #5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (link.frame_tx === 1'b1) begin
      fr_n <= fr_n + 1;
      fr_at <= cyc;
    end
    if (link.d2p_valid === 1'b1 && link.d2p_kind === cantt_pkg::MSG_HOLD) begin
      holds <= holds + 1;
    end
    if (cyc == 40000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  // polls status; bounded so a stuck engine ends as a mismatch
  task automatic wait_st(input int b);
    rv = 32'h0;
    for (int k = 0; k < 6000 && rv[b] !== 1'b1; k++) rd(8'h08);
    chk(rv[b], 1'b1);
  endtask
  task automatic frame_in(input int lo, input int hi);
    int n;
    n = fr_n;
    for (int k = 0; k < 2000 && fr_n == n; k++) @(posedge i_clk_sys);
    #1 chk(32'(fr_at - t0 >= lo && fr_at - t0 <= hi), 32'h1);
    t0 = fr_at;
  endtask
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    foreach (tv[i]) rc(8'h10 + 8'(i) * 8'h04, tv[i]);
    rc(8'h28, 32'hffffffff);
    rc(8'h2c, 32'h64);
    rc(8'h34, 32'h10);
    rc(8'h40, 32'h0);
    $display("defaults done");
    wr(8'h0c, 32'h10);
    wr(8'h04, 32'h0301);
    wait_st(4);
    chk(o_irq, 1'b1);
    wr(8'h08, 32'h10);
    rc(8'h08, 32'h0);
    chk(o_irq, 1'b0);
    $display("originator done");
    wr(8'h00, 32'h2);
    i_send_rts <= 1'b1;
    @(posedge i_clk_sys);
    i_send_rts <= 1'b0;
    repeat (40) @(posedge i_clk_sys);
    chk(32'(holds != 0), 32'h1);
    rc(8'h08, 32'h0);
    wr(8'h00, 32'h0);
    wait_st(5);
    chk(rv[3:0], 4'h0);
    wr(8'h08, 32'hff);
    $display("responder done");
    wr(8'h04, 32'h0302);
    wait_st(6);
    wr(8'h08, 32'hff);
    $display("broadcast done");
    // far end keeps holding from here on, so T4 must fire
    wr(8'h24, 32'h1);
    i_busy <= 1'b1;
    wr(8'h04, 32'h0101);
    wait_st(3);
    chk(o_irq, 1'b0);
    wr(8'h0c, 32'h08);
    rd(8'h08);
    chk(o_irq, 1'b1);
    wr(8'h08, 32'h08);
    rc(8'h08, 32'h0);
    chk(o_irq, 1'b0);
    $display("timeout done");
    wr(8'h28, 32'h5);
    wr(8'h2c, 32'h4);
    wr(8'h00, 32'h1);
    t0 = cyc;
    frame_in(4 * TC, 5 * TC + 4);
    frame_in(4 * TC, 4 * TC);
    rc(8'h34, 32'h40);
    wr(8'h2c, 32'h1e);
    t0 = cyc;
    frame_in(4 * TC, 5 * TC + 4);
    frame_in(30 * TC, 30 * TC);
    rc(8'h34, 32'h40);
    wr(8'h00, 32'h0);
    wr(8'h28, 32'hffffffff);
    wr(8'h30, 32'h7);
    wr(8'h00, 32'h1);
    t0 = cyc;
    frame_in(6 * TC, 7 * TC + 4);
    wr(8'h00, 32'h0);
    rd(8'h08);
    chk(rv[7], 1'b1);
    chk(o_frames, 16'(fr_n));
    $display("cyclic done");
    end_sim();
  end
endmodule
`default_nettype wire
